/* rtl/vic_core.sv */
// Processor core end: AXI4-Lite command registers driving the link
`timescale 1ns/1ps
module vic_core
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller link
  vic_link_if.core         link
);

  // ==========================================================
  // State
  vic_state_t  st_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        req_r;
  logic        we_r;
  logic [31:0] addr_r;
  logic [31:0] lwdata_r;
  logic        interrupt_acknowledge_cycle_r;
  logic [31:0] lrdata_r;
  logic [7:0]  ivec_r;
  logic        ivec_ok_r;

  // ==========================================================
  // Decode
  wire        do_wr   = aw_have_r & w_have_r & ~bvalid_r;
  wire        wa_ok   = awaddr_r == H_ADDR || awaddr_r == H_WDATA ||
                        awaddr_r == H_GO;
  wire        go      = do_wr & (awaddr_r == H_GO) & (st_r == VIC_IDLE);
  wire        go_rd   = go & wdata_r[GO_RD];
  // A link write is a whole word: narrow strobes are not passed on
  wire        go_wr   = go & wdata_r[GO_WR] & ~wdata_r[GO_RD];
  // Acknowledge only while the controller raises its request
  wire        go_ack  = do_wr & (awaddr_r == H_GO) & wdata_r[GO_ACK]
                        & link.intr & ~interrupt_acknowledge_cycle_r;
  wire        ar_take = s_axi_arvalid & ~rvalid_r;
  wire [31:0] stat    = {15'h0, link.intr, 6'h0, ivec_ok_r,
                         8'h0, st_r == VIC_WAIT};
  wire [31:0] rsel    =
    s_axi_araddr == H_ADDR  ? addr_r :
    s_axi_araddr == H_WDATA ? lwdata_r :
    s_axi_araddr == H_STAT  ? stat :
    s_axi_araddr == H_RDATA ? lrdata_r :
    s_axi_araddr == H_IVEC  ? {24'h0, ivec_r} :
    32'h0;
  wire        ra_ok   = s_axi_araddr == H_ADDR || s_axi_araddr == H_WDATA
                        || s_axi_araddr == H_STAT || s_axi_araddr == H_RDATA
                        || s_axi_araddr == H_IVEC || s_axi_araddr == H_GO;

  // ==========================================================
  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h0;
      wdata_r   <= 32'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wstrb == 4'hf ? s_axi_wdata : 32'h0;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wa_ok ? RESP_OK : RESP_ERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rsel;
        rresp_r  <= ra_ok ? RESP_OK : RESP_ERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Link sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= VIC_IDLE;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      addr_r    <= 32'h0;
      lwdata_r  <= 32'h0;
      interrupt_acknowledge_cycle_r    <= 1'b0;
      lrdata_r  <= 32'h0;
      ivec_r    <= 8'h0;
      ivec_ok_r <= 1'b0;
    end else begin
      req_r  <= go_rd | go_wr;
      we_r   <= go_wr;
      interrupt_acknowledge_cycle_r <= go_ack;
      if (do_wr && awaddr_r == H_ADDR && st_r == VIC_IDLE) begin
        addr_r <= wdata_r;
      end
      if (do_wr && awaddr_r == H_WDATA && st_r == VIC_IDLE) begin
        lwdata_r <= wdata_r;
      end
      if (go_ack) begin
        ivec_ok_r <= 1'b0;
      end else if (interrupt_acknowledge_cycle_r) begin
        ivec_r    <= link.vector;
        ivec_ok_r <= 1'b1;
      end
      unique case (st_r)
        VIC_IDLE: begin
          if (go_rd || go_wr) begin
            st_r <= VIC_WAIT;
          end
        end
        VIC_WAIT: begin
          if (link.ack) begin
            st_r     <= VIC_IDLE;
            lrdata_r <= link.rdata;
          end
        end
      endcase
    end
  end

  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready  = ~w_have_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign link.req      = req_r;
  assign link.we       = we_r;
  assign link.addr     = addr_r;
  assign link.wdata    = lwdata_r;
  assign link.interrupt_acknowledge_cycle     = interrupt_acknowledge_cycle_r;

endmodule : vic_core

/* rtl/vic_ctrl.sv */
// Fixed-vector interrupt controller with down-counting timer
`timescale 1ns/1ps

module vic_ctrl
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Peripheral interrupt lines
  input  wire logic [31:0] irq_lines,
  // Core link
  vic_link_if.device       link
);

  // ==========================================================
  // Helpers
  // Returns {found, index} of the highest set bit
  function automatic logic [5:0] top_bit(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = {1'b1, i[4:0]};
      end
    end
    return r;
  endfunction : top_bit

  // ==========================================================
  // State
  logic [31:0] trig_r;
  logic [31:0] mask_r;
  logic [31:0] prev_r;
  logic [31:0] irr_r;
  logic [31:0] isr_r;
  logic [4:0]  idx_r;
  logic [5:0]  thr_r;
  logic [7:0]  siv_r;
  logic [3:0]  tline_r;
  logic        tmask_r;
  logic        tper_r;
  logic [31:0] reload_r;
  logic [31:0] count_r;
  logic        running_r;
  logic        intr_r;
  logic [7:0]  vec_r;
  logic        ack_r;
  logic [31:0] rdata_r;

  // ==========================================================
  // Access decode
  wire         wr      = link.req & link.we;
  wire         rd      = link.req & ~link.we;
  wire         hit_sel = link.addr == A_SEL;
  wire         hit_win = link.addr == A_WIN;
  wire         hit_thr = link.addr == A_THR;
  wire         hit_lvl = link.addr == A_LVL;
  wire         hit_eos = link.addr == A_EOS;
  wire         hit_siv = link.addr == A_SIV;
  wire         hit_isb = link.addr == A_ISB;
  wire         hit_prb = link.addr == A_PRB;
  wire         hit_tvs = link.addr == A_TVS;
  wire         hit_rld = link.addr == A_RLD;
  wire         hit_cnt = link.addr == A_CNT;

  // ==========================================================
  // Request acceptance
  wire [31:0]  rise     = irq_lines & ~prev_r;
  wire [31:0]  raw      = (trig_r & irq_lines) | (~trig_r & rise);
  wire         fire     = running_r & (count_r == 32'h0);
  wire [31:0]  tline_oh = 32'h1 << tline_r;
  wire [31:0]  tinj     = (fire & ~tmask_r) ? tline_oh : 32'h0;
  // Mask gates only acceptance, so already pending bits survive
  wire [31:0]  accept   = (raw | tinj) & ~mask_r;

  // ==========================================================
  // Priority resolution
  wire [5:0]   pend_top = top_bit(irr_r);
  wire [5:0]   isr_top  = top_bit(isr_r);
  wire [5:0]   pend_num = {1'b0, pend_top[4:0]};
  wire [5:0]   isr_num  = {1'b0, isr_top[4:0]};
  wire         above_th = pend_num >= thr_r;
  wire         preempts = ~isr_top[5] | (pend_num > isr_num);
  wire         deliver  = pend_top[5] & above_th & preempts;
  wire [5:0]   lvl      = (isr_top[5] && isr_num > thr_r) ?
                          isr_num : thr_r;

  // ==========================================================
  // Acknowledge and end of service
  // The vector shown is the one taken, even if a newer line just arrived
  wire         take     = link.interrupt_acknowledge_cycle & intr_r;
  wire [31:0]  take_oh  = take ? (32'h1 << vec_r[4:0]) : 32'h0;
  wire [31:0]  irr_clr  = take_oh & ~irq_lines;
  wire         eos      = wr & hit_eos;
  wire [31:0]  eos_oh   = (eos & isr_top[5]) ?
                          (32'h1 << isr_top[4:0]) : 32'h0;
  // Set wins over clear in both bit sets
  wire [31:0]  irr_nxt  = (irr_r & ~irr_clr) | accept;
  wire [31:0]  isr_nxt  = (isr_r & ~eos_oh) | take_oh;

  // ==========================================================
  // Read data selection
  wire [31:0]  sel_rd   = {25'h0, idx_r[4:3], 1'b0, idx_r[2:0], 1'b0};
  wire [31:0]  win_rd   = {15'h0, mask_r[idx_r], trig_r[idx_r], 15'h0};
  wire [31:0]  tvs_rd   = {14'h0, tper_r, tmask_r, 12'h0, tline_r};
  wire [31:0]  rd_val   =
    hit_sel ? sel_rd :
    hit_win ? win_rd :
    hit_thr ? {26'h0, thr_r} :
    hit_lvl ? {26'h0, lvl} :
    hit_siv ? {24'h0, siv_r} :
    hit_isb ? isr_r :
    hit_prb ? irr_r :
    hit_tvs ? tvs_rd :
    hit_rld ? reload_r :
    hit_cnt ? count_r :
    32'h0;

  // ==========================================================
  // Interrupt state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 32'h0;
      irr_r  <= 32'h0;
      isr_r  <= 32'h0;
      intr_r <= 1'b0;
      vec_r  <= VEC_BASE;
    end else begin
      prev_r <= irq_lines;
      irr_r  <= irr_nxt;
      isr_r  <= isr_nxt;
      intr_r <= deliver & ~take;
      vec_r  <= VEC_BASE + {3'h0, pend_top[4:0]};
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_r  <= TRIG_RST;
      mask_r  <= MASK_RST;
      idx_r   <= 5'h0;
      thr_r   <= 6'h0;
      siv_r   <= SIV_RST;
      tline_r <= 4'h0;
      tmask_r <= 1'b0;
      tper_r  <= 1'b0;
    end else if (wr) begin
      if (hit_sel) begin
        idx_r <= {link.wdata[6:5], link.wdata[3:1]};
      end
      if (hit_win) begin
        trig_r[idx_r] <= link.wdata[TRIG_BIT];
        mask_r[idx_r] <= link.wdata[MASK_BIT];
      end
      if (hit_thr) begin
        // Values above 32 are clipped to the full block
        thr_r <= (link.wdata > 32'h20) ?
                 THR_BLOCK : link.wdata[5:0];
      end
      if (hit_siv) begin
        siv_r <= link.wdata[7:0];
      end
      if (hit_tvs) begin
        tline_r <= link.wdata[3:0];
        tmask_r <= link.wdata[TMASK_BIT];
        tper_r  <= link.wdata[TPER_BIT];
      end
    end
  end

  // ==========================================================
  // Timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r  <= 32'h0;
      count_r   <= 32'h0;
      running_r <= 1'b0;
    end else if (wr && hit_rld) begin
      reload_r  <= link.wdata;
      count_r   <= link.wdata;
      running_r <= link.wdata != 32'h0;
    end else if (fire) begin
      if (tper_r) begin
        count_r <= reload_r;
      end else begin
        running_r <= 1'b0;
      end
    end else if (running_r) begin
      count_r <= count_r - 32'h1;
    end
  end

  // ==========================================================
  // Link answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= link.req;
      rdata_r <= rd ? rd_val : 32'h0;
    end
  end

  assign link.ack    = ack_r;
  assign link.rdata  = rdata_r;
  assign link.intr   = intr_r;
  assign link.vector = vec_r;

endmodule : vic_ctrl

/* rtl/vic_link_if.sv */
// Link between the interrupt controller and the processor core end
`timescale 1ns/1ps
interface vic_link_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        intr;
  logic [7:0]  vector;
  logic        interrupt_acknowledge_cycle;

  modport device (
    input  req, we, addr, wdata, interrupt_acknowledge_cycle,
    output rdata, ack, intr, vector
  );
  modport core (
    output req, we, addr, wdata, interrupt_acknowledge_cycle,
    input  rdata, ack, intr, vector
  );
endinterface : vic_link_if

/* rtl/vic_pkg.sv */
// Shared constants for the vectored interrupt controller and its core end
package vic_pkg;

  // ==========================================================
  // Line count and vector numbering
  localparam int unsigned NUM_LINES = 32;
  localparam logic [7:0]  VEC_BASE  = 8'h20;

  // ==========================================================
  // Controller register addresses on the core link
  localparam logic [31:0] A_SEL = 32'hfec00000;
  localparam logic [31:0] A_WIN = 32'hfec00010;
  localparam logic [31:0] A_THR = 32'hfee00080;
  localparam logic [31:0] A_LVL = 32'hfee000a0;
  localparam logic [31:0] A_EOS = 32'hfee000b0;
  localparam logic [31:0] A_SIV = 32'hfee000f0;
  localparam logic [31:0] A_ISB = 32'hfee00110;
  localparam logic [31:0] A_PRB = 32'hfee00210;
  localparam logic [31:0] A_TVS = 32'hfee00320;
  localparam logic [31:0] A_RLD = 32'hfee00380;
  localparam logic [31:0] A_CNT = 32'hfee00390;

  // ==========================================================
  // Field positions
  localparam int unsigned TRIG_BIT   = 15;
  localparam int unsigned MASK_BIT   = 16;
  localparam int unsigned TMASK_BIT  = 16;
  localparam int unsigned TPER_BIT   = 17;
  localparam logic [5:0]  THR_BLOCK  = 6'h20;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] TRIG_RST = 32'h0000_0000;
  localparam logic [7:0]  SIV_RST  = 8'hff;

  // ==========================================================
  // Core end register map (AXI4-Lite byte addresses)
  localparam logic [7:0] H_ADDR  = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_GO    = 8'h08;
  localparam logic [7:0] H_STAT  = 8'h0c;
  localparam logic [7:0] H_RDATA = 8'h10;
  localparam logic [7:0] H_IVEC  = 8'h14;
  localparam int unsigned GO_RD   = 0;
  localparam int unsigned GO_WR   = 1;
  localparam int unsigned GO_ACK  = 2;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef enum logic [0:0] {
    VIC_IDLE = 1'b0,
    VIC_WAIT = 1'b1
  } vic_state_t;

endpackage : vic_pkg

/* test/fixed_vector_irq_controller_tb_top.sv */
// Bench for the interrupt controller and its core end
`timescale 1ns/1ps
module fixed_vector_irq_controller_tb_top import vic_pkg::*;;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] irq, wdata, rdata, r;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  logic [31:0] ra [6];
  logic [31:0] rv [6];
  int          bad_count, cmp_count;

  vic_link_if link();
  vic_ctrl i_vic_ctrl (.aclk(aclk), .aresetn(aresetn), .irq_lines(irq),
    .link(link));
  vic_core i_vic_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  vic_asserts i_vic_asserts (.aclk(aclk), .aresetn(aresetn),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .intr(link.intr),
    .vector(link.vector), .interrupt_acknowledge_cycle(link.interrupt_acknowledge_cycle));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Only the watchdog ends a wait for an answer
  task automatic aw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : aw

  task automatic ar(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : ar

  // Busy is polled, so no latency of the core end is assumed
  task automatic go(input logic [31:0] cmd);
    aw(H_GO, cmd);
    do begin
      ar(H_STAT, r);
    end while (r[0] !== 1'b0);
  endtask : go

  task automatic dw(input logic [31:0] a, d);
    aw(H_ADDR, a);
    aw(H_WDATA, d);
    go(32'h2);
  endtask : dw

  task automatic dr(input logic [31:0] a, output logic [31:0] d);
    aw(H_ADDR, a);
    go(32'h1);
    ar(H_RDATA, d);
  endtask : dr

  task automatic cfg(input logic [4:0] n, input logic [31:0] w);
    dw(A_SEL, {25'h0, n[4:3], 1'b0, n[2:0], 1'b0});
    dw(A_WIN, w);
  endtask : cfg

  // A stale vector would pass unless the request is seen raised first
  task automatic svc(input logic [7:0] v, input logic eos);
    repeat (2) @(posedge aclk);
    intr_chk(1'b1);
    go(32'h4);
    ar(H_IVEC, r);
    chk("ack vector", r, {24'h0, v});
    if (eos) dw(A_EOS, 32'hffffffff);
  endtask : svc

  task automatic pulse(input int n);
    @(posedge aclk);
    irq[n] <= 1'b1;
    @(posedge aclk);
    irq[n] <= 1'b0;
  endtask : pulse

  task automatic intr_chk(input logic e);
    ar(H_STAT, r);
    chk("intr", {31'h0, r[16]}, {31'h0, e});
  endtask : intr_chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // About sixteen times the expected run length
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {irq, wdata, awaddr, araddr} = 80'h0;
    wstrb = 4'hf;
    bad_count = 0;
    cmp_count = 0;
    ra = '{A_THR, A_SIV, A_ISB, A_PRB, A_CNT, A_LVL};
    rv = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      dr(ra[i], r);
      chk("reset value", r, rv[i]);
    end
    // Reset state is read before each line is programmed
    for (int i = 0; i < 32; i++) begin
      dw(A_SEL, {25'h0, i[4:3], 1'b0, i[2:0], 1'b0});
      dr(A_WIN, r);
      chk("line config", r, 32'h0);
      dw(A_WIN, 32'h0);
    end
    dw(A_SEL, 32'hffffffff);
    dr(A_SEL, r);
    chk("index", r, 32'h6e);
    aw(8'h1c, 32'h1);
    chk("bad address", {30'h0, rs}, {30'h0, RESP_ERR});
    ar(8'h1c, r);
    chk("bad read", {30'h0, rs}, {30'h0, RESP_ERR});
    ar(H_STAT, r);
    chk("read resp", {30'h0, rs}, {30'h0, RESP_OK});
    wstrb <= 4'h3;
    aw(H_WDATA, 32'h55);
    wstrb <= 4'hf;
    ar(H_WDATA, r);
    chk("narrow write", r, 32'h0);
    // Masked line is dropped; masking after accept keeps it
    cfg(5'd5, 32'h10000);
    pulse(5);
    dr(A_PRB, r);
    chk("masked pending", r, 32'h0);
    cfg(5'd5, 32'h0);
    pulse(6);
    cfg(5'd6, 32'h10000);
    dr(A_PRB, r);
    chk("accepted pending", r, 32'h40);
    cfg(5'd6, 32'h0);
    svc(8'h26, 1'b1);
    pulse(3);
    pulse(9);
    dr(A_PRB, r);
    chk("pending", r, 32'h208);
    svc(8'h29, 1'b0);
    dr(A_ISB, r);
    chk("in service", r, 32'h200);
    pulse(12);
    svc(8'h2c, 1'b0);
    dr(A_LVL, r);
    chk("level", r, 32'hc);
    intr_chk(1'b0);
    dw(A_EOS, 32'h12345678);
    dr(A_ISB, r);
    chk("after end", r, 32'h200);
    dw(A_EOS, 32'h0);
    svc(8'h23, 1'b1);
    dw(A_THR, 32'ha);
    dr(A_LVL, r);
    chk("level", r, 32'ha);
    pulse(4);
    intr_chk(1'b0);
    pulse(20);
    dw(A_THR, 32'h20);
    intr_chk(1'b0);
    dw(A_THR, 32'h0);
    svc(8'h34, 1'b1);
    svc(8'h24, 1'b1);
    // Level line high at acknowledge stays pending
    cfg(5'd7, 32'h8000);
    irq[7] <= 1'b1;
    svc(8'h27, 1'b0);
    dr(A_PRB, r);
    chk("level pending", r, 32'h80);
    irq[7] <= 1'b0;
    dw(A_EOS, 32'h0);
    svc(8'h27, 1'b1);
    cfg(5'd7, 32'h0);
    // Timer: one-shot, restart, stop, periodic, masked
    dw(A_TVS, 32'h2);
    dw(A_RLD, 32'hc8);
    dr(A_CNT, r);
    chk("count", {31'h0, r > 0 && r < 32'hc8}, 32'h1);
    repeat (250) @(posedge aclk);
    dr(A_CNT, r);
    chk("stopped", r, 32'h0);
    svc(8'h22, 1'b1);
    dw(A_RLD, 32'h3e8);
    dw(A_RLD, 32'h64);
    dr(A_CNT, r);
    chk("restart", {31'h0, r > 0 && r <= 32'h64}, 32'h1);
    dw(A_RLD, 32'h0);
    dr(A_CNT, r);
    chk("halted", r, 32'h0);
    dw(A_TVS, 32'h20003);
    dw(A_RLD, 32'h64);
    repeat (150) @(posedge aclk);
    svc(8'h23, 1'b1);
    repeat (120) @(posedge aclk);
    dw(A_RLD, 32'h0);
    svc(8'h23, 1'b1);
    dw(A_TVS, 32'h10003);
    dw(A_RLD, 32'h20);
    repeat (60) @(posedge aclk);
    dr(A_PRB, r);
    chk("timer masked", r, 32'h0);
    stop_test();
  end
endmodule : fixed_vector_irq_controller_tb_top

/* test/vic_asserts.sv */
// Link checks for the interrupt controller
`timescale 1ns/1ps
module vic_asserts
  import vic_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link
  input wire logic        req,
  input wire logic        we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        intr,
  input wire logic [7:0]  vector,
  input wire logic        interrupt_acknowledge_cycle
);
  // ==========================================================
  // Threshold shadow, one cycle late because intr is registered
  logic [5:0] thr_r;
  logic [5:0] thr_d_r;
  wire        thr_we  = req && we && (addr == A_THR);
  wire  [5:0] thr_nxt = (wdata > 32'h20) ? 6'h20 : wdata[5:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_r   <= 6'h00;
      thr_d_r <= 6'h00;
    end else begin
      thr_r   <= thr_we ? thr_nxt : thr_r;
      thr_d_r <= thr_r;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Assertions
  a_ack_timing: assert property (req |=> ack ##1 !ack)
    else $error("link answer is not one pulse after the request");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("link answer without a request");
  a_vec_range: assert property (
    intr |-> vector >= 8'h20 && vector <= 8'h3f)
    else $error("vector outside the line range");
  a_interrupt_acknowledge_cycle_drop: assert property (interrupt_acknowledge_cycle && intr |=> !intr)
    else $error("request still raised after acknowledge");
  a_thr_floor: assert property (
    intr |-> vector >= {2'b00, thr_d_r} + 8'h20)
    else $error("line below threshold delivered");
  a_thr_all: assert property (thr_d_r == 6'h20 |-> !intr)
    else $error("delivery with threshold at 32");
  a_sel_bits: assert property (
    ack && $past(req && !we && addr == A_SEL)
    |-> (rdata & 32'hffffff91) == 32'h0)
    else $error("reserved index bits read back set");
  a_lvl_floor: assert property (
    ack && $past(req && !we && addr == A_LVL)
    |-> rdata >= {26'h0, thr_d_r} && rdata <= 32'h20)
    else $error("priority level below threshold");
endmodule : vic_asserts
